/* src/cpm_pkg.sv */
`default_nettype none
package cpm_pkg;
  // Bus and storage geometry
  localparam int unsigned PADDR_W    = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned INSN_W     = 16;
  localparam int unsigned MEM_AW_DEF = 12;
  localparam int unsigned PTR_W      = 14;
  localparam int unsigned PTR_CNT    = 3;
  localparam int unsigned PTR_HI_LSB = 10;
  localparam int unsigned IDX_PTR    = 2;
  // Register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_CTRL   = 8'h04;
  localparam logic [7:0] OFS_BANK   = 8'h08;
  localparam logic [7:0] OFS_ACC    = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PTR0   = 8'h14;
  localparam logic [7:0] OFS_MADDR  = 8'h20;
  localparam logic [7:0] OFS_MDATA  = 8'h24;
  // Field positions
  localparam int unsigned CTRL_EXT  = 0;
  localparam int unsigned STS_Z     = 0;
  localparam int unsigned STS_N     = 1;
  localparam int unsigned STS_BUSY  = 4;
  localparam int unsigned STS_WAIT  = 5;
  localparam int unsigned STS_ILL   = 8;
  localparam int unsigned MOV_D_BIT = 9;
  localparam int unsigned MOV_A_BIT = 8;
  // Opcode patterns
  localparam logic [7:0] PTR_OP1     = 8'hee;
  localparam logic [5:0] PTR_OP2     = 6'h3c;
  localparam logic [5:0] MOVE_OP     = 6'h14;
  localparam logic [1:0] PTR_SEL_BAD = 2'h3;
  localparam logic [7:0] ACC_LIMIT   = 8'h5f;
  // Quarter phases of one instruction cycle
  localparam logic [1:0] Q_FIRST = 2'h0;
  localparam logic [1:0] Q_READ  = 2'h1;
  localparam logic [1:0] Q_LAST  = 2'h3;
  // Reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_CYC1  = 2'b01,
    ST_WAIT2 = 2'b11,
    ST_CYC2  = 2'b10
  } cpm_state_t;
endpackage
`default_nettype wire

/* src/cpm_core.sv */
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RQ1: Pointer load puts 14-bit literal in pointer 0..2; flags untouched.
// RQ2: First cycle writes literal bits 13:10 into pointer bits 13:10.
// RQ3: Second word's bits 9:0 go to pointer bits 9:0; two cycles total.
// RQ4: Move with d=0 copies byte to accumulator; d=1 writes it back.
// RQ5: a=0 addresses access bank; a=1 uses bank select register.
// RQ6: Extended set, a=0, f<=95 uses indexed literal-offset address.
// RQ7: Move sets N from bit 7, Z from zero byte; f spans 0..255.
module cpm_core #(
  parameter int unsigned MEM_AW = cpm_pkg::MEM_AW_DEF
) (
  // Clock and reset
  input  wire logic                         REF_CLK,
  input  wire logic                         RESETN,
  // APB slave
  input  wire logic                         PSEL,
  input  wire logic                         PENABLE,
  input  wire logic                         PWRITE,
  input  wire logic [cpm_pkg::PADDR_W-1:0]  PADDR,
  input  wire logic [cpm_pkg::DATA_W-1:0]   PWDATA,
  output var  logic [cpm_pkg::DATA_W-1:0]   PRDATA,
  output var  logic                         PREADY,
  output var  logic                         PSLVERR
);
  import cpm_pkg::*;

  localparam int unsigned BANK_W = MEM_AW - 8;

  function automatic logic [7:0] ptr_ofs(input int unsigned i);
    return OFS_PTR0 + 8'(4 * i);
  endfunction

  logic [1:0]          rst_ff;
  logic                rst_n;
  cpm_state_t          state;
  logic [1:0]          qph;
  logic [INSN_W-1:0]   ir;
  logic [9:0]          klo;
  logic                is_mov;
  logic [PTR_W-1:0]    ptr [PTR_CNT];
  logic [7:0]          acc;
  logic [7:0]          mdata;
  logic                flag_n;
  logic                flag_z;
  logic                ext_en;
  logic [BANK_W-1:0]   bank;
  logic                ill;
  logic [MEM_AW-1:0]   maddr;
  logic [7:0]          mem [2**MEM_AW];
  logic [DATA_W-1:0]   rdata;
  logic [DATA_W-1:0]   stat;

  // Reset release through two flops
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  // Bus decode
  wire       acc_ph    = PSEL & PENABLE & PREADY;
  wire       wr        = acc_ph & PWRITE;
  wire       busy      = (state == ST_CYC1) | (state == ST_CYC2);
  wire       take      = PSEL & PENABLE & ~PREADY & ~busy;
  wire       hit_instr = PADDR == OFS_INSTR;
  wire       hit_ctrl  = PADDR == OFS_CTRL;
  wire       hit_bank  = PADDR == OFS_BANK;
  wire       hit_acc   = PADDR == OFS_ACC;
  wire       hit_stat  = PADDR == OFS_STATUS;
  wire       hit_maddr = PADDR == OFS_MADDR;
  wire       hit_mdata = PADDR == OFS_MDATA;
  wire       hit_ptr   = (PADDR == ptr_ofs(0)) | (PADDR == ptr_ofs(1))
                       | (PADDR == ptr_ofs(2));
  wire       mapped    = hit_instr | hit_ctrl | hit_bank | hit_acc
                       | hit_stat | hit_maddr | hit_mdata | hit_ptr;

  // Instruction decode
  wire       w_is_mov  = PWDATA[15:10] == MOVE_OP;
  wire       w_is_ptr  = (PWDATA[15:8] == PTR_OP1) & (PWDATA[7:6] == 2'h0)
                       & (PWDATA[5:4] != PTR_SEL_BAD);
  wire       w_is_ptr2 = PWDATA[15:10] == PTR_OP2;
  wire       go_idle   = wr & hit_instr & (state == ST_IDLE);
  wire       go_w2     = wr & hit_instr & (state == ST_WAIT2);
  wire       set_ill   = (go_idle & ~w_is_mov & ~w_is_ptr)
                       | (go_w2 & ~w_is_ptr2);
  wire [1:0] sel       = ir[5:4];
  wire [7:0] f         = ir[7:0];
  wire       d_bit     = ir[MOV_D_BIT];
  wire       a_bit     = ir[MOV_A_BIT];
  wire       q4        = qph == Q_LAST;
  wire       mov_wb    = (state == ST_CYC1) & is_mov & q4;
  wire       hi_wr     = (state == ST_CYC1) & ~is_mov & q4;
  wire       lo_wr     = (state == ST_CYC2) & q4;

  // Effective address of the move
  wire       low_f     = f <= ACC_LIMIT;
  wire       indexed   = ext_en & ~a_bit & low_f;   // [RQ6]
  wire [MEM_AW-1:0] ea_idx  = ptr[IDX_PTR][MEM_AW-1:0] + MEM_AW'(f);
  wire [MEM_AW-1:0] ea_bank = {bank, f};
  wire [MEM_AW-1:0] ea_acc  = low_f ? MEM_AW'(f) : {{BANK_W{1'b1}}, f};
  wire [MEM_AW-1:0] ea      = indexed ? ea_idx
                            : (a_bit ? ea_bank : ea_acc);   // [RQ5]

  always_comb begin
    stat           = '0;
    stat[STS_Z]    = flag_z;
    stat[STS_N]    = flag_n;
    stat[STS_BUSY] = busy;
    stat[STS_WAIT] = state == ST_WAIT2;
    stat[STS_ILL]  = ill;
  end

  always_comb begin
    rdata = '0;
    if (hit_instr) rdata[INSN_W-1:0] = ir;
    if (hit_ctrl)  rdata[CTRL_EXT] = ext_en;
    if (hit_bank)  rdata[BANK_W-1:0] = bank;
    if (hit_acc)   rdata[7:0] = acc;
    if (hit_stat)  rdata = stat;
    if (hit_maddr) rdata[MEM_AW-1:0] = maddr;
    if (hit_mdata) rdata[7:0] = mem[maddr];
    for (int i = 0; i < PTR_CNT; i++) begin
      if (PADDR == ptr_ofs(i)) rdata[PTR_W-1:0] = ptr[i];
    end
  end

  // APB answer: one wait state, held off while executing
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= '0;
    end else begin
      PREADY <= take;
      if (take) begin
        PRDATA  <= PWRITE ? '0 : rdata;
        PSLVERR <= ~mapped;
      end
    end
  end

  // Sequencer and architectural state
  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state  <= ST_IDLE;
      qph    <= Q_FIRST;
      ir     <= RST_WORD;
      klo    <= '0;
      is_mov <= 1'b0;
      acc    <= RST_BYTE;
      mdata  <= RST_BYTE;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      ext_en <= 1'b0;
      bank   <= '0;
      ill    <= 1'b0;
      maddr  <= '0;
      for (int i = 0; i < PTR_CNT; i++) ptr[i] <= '0;
    end else begin
      qph <= busy ? qph + 2'h1 : Q_FIRST;
      if (wr & hit_ctrl)  ext_en <= PWDATA[CTRL_EXT];
      if (wr & hit_bank)  bank <= PWDATA[BANK_W-1:0];
      if (wr & hit_acc)   acc <= PWDATA[7:0];
      if (wr & hit_maddr) maddr <= PWDATA[MEM_AW-1:0];
      for (int i = 0; i < PTR_CNT; i++) begin
        if (wr & (PADDR == ptr_ofs(i))) ptr[i] <= PWDATA[PTR_W-1:0];
      end
      // Illegal word flag: a new event wins over the clear
      if (set_ill) begin
        ill <= 1'b1;
      end else if (wr & hit_stat & PWDATA[STS_ILL]) begin
        ill <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (go_idle & (w_is_mov | w_is_ptr)) begin
            ir     <= PWDATA[INSN_W-1:0];
            is_mov <= w_is_mov;
            state  <= ST_CYC1;   // [RQ1]
          end
        end
        ST_CYC1: begin
          if (is_mov & (qph == Q_READ)) mdata <= mem[ea];
          if (q4) state <= is_mov ? ST_IDLE : ST_WAIT2;
        end
        ST_WAIT2: begin
          if (go_w2) begin
            klo   <= PWDATA[9:0];
            state <= w_is_ptr2 ? ST_CYC2 : ST_IDLE;
          end
        end
        ST_CYC2: begin
          if (q4) state <= ST_IDLE;   // [RQ3]
        end
        default: state <= ST_IDLE;
      endcase
      if (hi_wr) ptr[sel][PTR_W-1:PTR_HI_LSB] <= ir[3:0];   // [RQ2]
      if (lo_wr) ptr[sel][PTR_HI_LSB-1:0] <= klo;           // [RQ3]
      if (mov_wb) begin
        if (!d_bit) acc <= mdata;                            // [RQ4]
        flag_n <= mdata[7];                                  // [RQ7]
        flag_z <= mdata == RST_BYTE;                         // [RQ7]
      end
    end
  end

  // Data memory; bus writes are stalled while executing
  always_ff @(posedge REF_CLK) begin
    if (mov_wb & d_bit) begin
      mem[ea] <= mdata;   // [RQ4]
    end else if (wr & hit_mdata) begin
      mem[maddr] <= PWDATA[7:0];
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  property p_ptr_flags;
    (state != ST_IDLE) && !is_mov |=> $stable({flag_n, flag_z});
  endproperty
  a_ptr_flags: assert property (p_ptr_flags) // [RQ1]
    else $error("flags moved during pointer load");

  property p_ptr_hi;
    hi_wr |=> (ptr[sel][PTR_W-1:PTR_HI_LSB] == $past(ir[3:0]))
              && (state == ST_WAIT2);
  endproperty
  a_ptr_hi: assert property (p_ptr_hi) // [RQ2]
    else $error("pointer high bits not loaded");

  property p_ptr_lo;
    (state == ST_CYC2) && (qph == Q_FIRST) |-> ##3 lo_wr
      ##1 (ptr[sel][PTR_HI_LSB-1:0] == $past(klo)) && (state == ST_IDLE);
  endproperty
  a_ptr_lo: assert property (p_ptr_lo) // [RQ3]
    else $error("pointer low bits not loaded in second cycle");

  property p_mov_acc;
    mov_wb && !d_bit |=> acc == $past(mdata);
  endproperty
  a_mov_acc: assert property (p_mov_acc) // [RQ4]
    else $error("move did not reach accumulator");

  property p_mov_back;
    mov_wb && d_bit |=> (mem[$past(ea)] == $past(mdata)) && $stable(acc);
  endproperty
  a_mov_back: assert property (p_mov_back) // [RQ4]
    else $error("move did not write back to file");

  property p_bank_addr;
    (state == ST_CYC1) && is_mov && !indexed |->
      (ea[7:0] == f) && (ea[MEM_AW-1:8] == (a_bit ? bank
        : (f <= ACC_LIMIT) ? {BANK_W{1'b0}} : {BANK_W{1'b1}}));
  endproperty
  a_bank_addr: assert property (p_bank_addr) // [RQ5]
    else $error("wrong banked address");

  property p_idx_addr;
    (state == ST_CYC1) && is_mov && ext_en && !a_bit && (f <= ACC_LIMIT)
      |-> ea == ptr[IDX_PTR][MEM_AW-1:0] + MEM_AW'(f);
  endproperty
  a_idx_addr: assert property (p_idx_addr) // [RQ6]
    else $error("wrong indexed address");

  property p_mov_flags;
    mov_wb |=> (flag_z == ($past(mdata) == RST_BYTE))
               && (flag_n == $past(mdata[7]));
  endproperty
  a_mov_flags: assert property (p_mov_flags) // [RQ7]
    else $error("move flags wrong");

  property p_stall;
    busy |-> !PREADY;
  endproperty
  a_stall: assert property (p_stall)
    else $error("bus answered while executing");

  property p_ill_sticky;
    set_ill |=> ill;
  endproperty
  a_ill_sticky: assert property (p_ill_sticky) // [RQ1]
    else $error("illegal word not flagged");

  property p_ptr_pair;
    go_w2 && !w_is_ptr2 |=> (state == ST_IDLE) && ill;
  endproperty
  a_ptr_pair: assert property (p_ptr_pair) // [RQ3]
    else $error("bad second word not refused");

  c_mov_acc:  cover property (mov_wb && !d_bit);
  c_mov_back: cover property (mov_wb && d_bit && indexed);
  c_ptr_done: cover property (lo_wr);
  c_illegal:  cover property (set_ill);
  c_ptr_bad2: cover property (go_w2 && !w_is_ptr2);

endmodule // cpm_core
`default_nettype wire

/* sim/tb_cpm_core.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  err_total++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_cpm_core;
  import cpm_pkg::*;
  logic        ref_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  int          err_total = 0;
  int          cmp_count = 0;
  logic [31:0] rd;
  logic        slv;

  cpm_core uut (
    .REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // One APB transfer; result left in rd and slv
  task automatic apb(input logic wr, input logic [7:0] adr,
                     input logic [31:0] wd);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= adr;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Preload a byte, run one move, judge accumulator, flags and memory
  task automatic mv(input logic d, input logic a, input logic [7:0] f,
                    input logic [11:0] adr, input logic [7:0] val);
    logic [31:0] acc0;
    apb(1'b0, OFS_ACC, 32'h0);
    acc0 = rd;
    apb(1'b1, OFS_MADDR, {20'h0, adr});
    apb(1'b1, OFS_MDATA, {24'h0, val});
    apb(1'b1, OFS_INSTR, {16'h0, MOVE_OP, d, a, f});
    apb(1'b0, OFS_ACC, 32'h0);
    `CHK(rd, (d ? acc0 : {24'h0, val}))
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[1:0], {val[7], (val == 8'h00)})
    apb(1'b0, OFS_MDATA, 32'h0);
    `CHK(rd[7:0], val)
  endtask

  task automatic t_move;
    apb(1'b1, OFS_BANK, 32'h3);
    mv(1'b0, 1'b1, 8'h80, 12'h380, 8'h85);
    mv(1'b1, 1'b1, 8'hff, 12'h3ff, 8'h00);
    mv(1'b0, 1'b0, 8'h5f, 12'h05f, 8'h7e);
    mv(1'b1, 1'b0, 8'h60, 12'hf60, 8'h01);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, 8'(OFS_PTR0 + 8), 32'h200);
    mv(1'b0, 1'b0, 8'h5f, 12'h25f, 8'h3c);
    mv(1'b0, 1'b0, 8'h60, 12'hf60, 8'h40);
    mv(1'b1, 1'b0, 8'h20, 12'h220, 8'h96);
    mv(1'b1, 1'b1, 8'h10, 12'h310, 8'hc3);
    apb(1'b1, OFS_CTRL, 32'h0);
  endtask

  // Two-word pointer load on every legal selector; flags left N=1 Z=0
  task automatic t_ptr;
    for (int s = 0; s < 3; s++) begin
      logic [1:0]  sv;
      logic [13:0] k;
      logic [7:0]  pa;
      sv = 2'(s);
      k = 14'h3ab ^ {sv, 12'hc50};
      pa = 8'(OFS_PTR0 + 4 * s);
      apb(1'b1, pa, 32'h155);
      apb(1'b1, OFS_INSTR, {16'h0, PTR_OP1, 2'b00, sv, k[13:10]});
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[5], 1'b1)
      apb(1'b0, pa, 32'h0);
      `CHK(rd, {18'h0, k[13:10], 10'h155})
      apb(1'b1, OFS_INSTR, {16'h0, PTR_OP2, k[9:0]});
      apb(1'b0, pa, 32'h0);
      `CHK(rd, {18'h0, k})
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK(rd[1:0], 2'b10)
    end
  endtask

  // Selector 3 refused, sticky flag cleared, unmapped access
  task automatic t_illegal;
    apb(1'b1, OFS_INSTR, {16'h0, PTR_OP1, 2'b00, PTR_SEL_BAD, 4'hf});
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[8], rd[5]}, 2'b10)
    apb(1'b0, OFS_PTR0, 32'h0);
    `CHK(rd, 32'hffb)
    apb(1'b1, OFS_STATUS, 32'h100);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[8], 1'b0)
    apb(1'b0, 8'hfc, 32'h0);
    `CHK({slv, rd}, {1'b1, 32'h0})
    // Bad second word: refused, high bits already loaded
    apb(1'b1, OFS_INSTR, {16'h0, PTR_OP1, 2'b00, 2'h1, 4'h5});
    apb(1'b1, OFS_INSTR, {16'h0, MOVE_OP, 10'h000});
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK({rd[8], rd[5]}, 2'b10)
    apb(1'b0, 8'(OFS_PTR0 + 4), 32'h0);
    `CHK(rd, 32'h17fb)
  endtask

  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_move;
    t_ptr;
    t_illegal;
    end_sim;
  end

  initial begin
    #200000;
    err_total++;
    end_sim;
  end
endmodule // tb_cpm_core
`default_nettype wire
